// ### verilog/hscd_top.sv
//Function
// - Port power enables are active-low push-pull outputs
// - Suspend status high in suspend, else low
// - Clock mode low selects PLL core clock
// - Clock mode high bypasses PLL, direct clock
// - PLL mode derives 48 and 12 MHz
// - Port strap 0 gives three, 1 two
// - Bus-powered always reports ports power-switched
// - Shared strap meaning depends on power mode
// - Bus-powered D4 follows overcurrent strap level
// - Self-powered always reports overcurrent protection
// - Self-powered power-good time 50 or 0
`timescale 1ns/1ns
module hscd_top (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    input  wire logic                        core_clock_bypass_strap,
    input  wire logic                        three_port_select_n,
    input  wire logic                        bus_power_select_n,
    input  wire logic                        overcurrent_protect_strap_n,
    input  wire logic [1:0]                  fixed_port_count_sel,
    input  wire logic [hscd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [hscd_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [hscd_pkg::DATA_W-1:0] reg_rdata,
    output logic      [2:0]                  port_power_enable_n,
    output logic                             suspend_status_out,
    output logic                             core_clock_pll,
    output logic                             slow_clock_tick,
    output logic      [15:0]                 hub_characteristics,
    output logic      [7:0]                  power_on_to_good,
    output logic      [1:0]                  port_count,
    output logic                             config_valid
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rst_sync_n = rst_s2_q;

    // ------------------------------------------------------------------
    // Strap pin filtering
    // ------------------------------------------------------------------
    logic [hscd_pkg::STRAP_W-1:0] strap_pins;
    logic [hscd_pkg::STRAP_W-1:0] strap_level;

    assign strap_pins = {fixed_port_count_sel,
                         overcurrent_protect_strap_n,
                         bus_power_select_n,
                         three_port_select_n,
                         core_clock_bypass_strap};

    hscd_strap_sync u_strap_sync (
        .clock     (clock),
        .rst_n     (rst_sync_n),
        .clk_en    (clk_en),
        .pins_in   (strap_pins),
        .level_out (strap_level)
    );

    // ------------------------------------------------------------------
    // Capture sequencer
    // ------------------------------------------------------------------
    hscd_pkg::hscd_state_t        state_q, state_d;
    logic [2:0]                   settle_q, settle_d;
    logic [hscd_pkg::STRAP_W-1:0] strap_q, strap_d;

    always_comb begin
        state_d  = state_q;
        settle_d = settle_q;
        strap_d  = strap_q;
        case (state_q)
            hscd_pkg::HSCD_SETTLE: begin
                if (settle_q == hscd_pkg::SETTLE_CYCLES) begin
                    strap_d = strap_level;
                    state_d = hscd_pkg::HSCD_RUN;
                end else begin
                    settle_d = settle_q + 3'h1;
                end
            end
            hscd_pkg::HSCD_RUN: begin
                strap_d = strap_q;
            end
            default: begin
                state_d = hscd_pkg::HSCD_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q  <= hscd_pkg::HSCD_SETTLE;
            settle_q <= 3'h0;
            strap_q  <= hscd_pkg::STRAP_RESET;
        end else if (clk_en) begin
            state_q  <= state_d;
            settle_q <= settle_d;
            strap_q  <= strap_d;
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------------
    logic running;
    logic bypass;
    logic three_ports;
    logic self_powered;
    logic shared_strap_n;
    logic oc_strap_n;
    logic sw_strap_n;

    assign running        = (state_q == hscd_pkg::HSCD_RUN);
    assign bypass         = strap_q[hscd_pkg::STRAP_BYPASS];
    assign three_ports    = ~strap_q[hscd_pkg::STRAP_THREE_N];
    assign self_powered   = strap_q[hscd_pkg::STRAP_BUS_PWR_N];
    assign shared_strap_n = strap_q[hscd_pkg::STRAP_PROT_SW_N];
    // Shared strap is overcurrent indication or switching indication
    assign oc_strap_n     = self_powered ? 1'b0 : shared_strap_n;
    assign sw_strap_n     = self_powered ? shared_strap_n : 1'b0;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [3:0] ctrl_q, ctrl_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr && (reg_addr == hscd_pkg::REG_CTRL)) begin
            ctrl_d = reg_wdata[3:0];
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_q <= hscd_pkg::CTRL_RESET;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // Descriptor reporting
    // ------------------------------------------------------------------
    logic [15:0] hub_char_q, hub_char_d;
    logic [7:0]  pwr_good_q, pwr_good_d;
    logic [1:0]  ports_q, ports_d;
    logic        valid_q, valid_d;

    always_comb begin
        hub_char_d = hscd_pkg::HUB_CHAR_RESET;
        pwr_good_d = hscd_pkg::PWR_GOOD_NONE;
        ports_d    = three_ports ? hscd_pkg::PORTS_THREE : hscd_pkg::PORTS_TWO;
        valid_d    = running;
        if (!self_powered) begin
            hub_char_d[1:0] = hscd_pkg::HUB_SW_PER_PORT;
            hub_char_d[hscd_pkg::HUB_CHAR_OC_BIT] = oc_strap_n;
            pwr_good_d = hscd_pkg::PWR_GOOD_SWITCHED;
        end else begin
            hub_char_d[hscd_pkg::HUB_CHAR_OC_BIT] = 1'b0;
            if (!sw_strap_n) begin
                hub_char_d[1:0] = hscd_pkg::HUB_SW_PER_PORT;
                pwr_good_d = hscd_pkg::PWR_GOOD_SWITCHED;
            end else begin
                hub_char_d[1:0] = hscd_pkg::HUB_SW_NONE;
                pwr_good_d = hscd_pkg::PWR_GOOD_NONE;
            end
        end
        if (!running) begin
            hub_char_d = hscd_pkg::HUB_CHAR_RESET;
            pwr_good_d = hscd_pkg::PWR_GOOD_NONE;
            ports_d    = 2'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hub_char_q <= hscd_pkg::HUB_CHAR_RESET;
            pwr_good_q <= hscd_pkg::PWR_GOOD_NONE;
            ports_q    <= 2'h0;
            valid_q    <= 1'b0;
        end else if (clk_en) begin
            hub_char_q <= hub_char_d;
            pwr_good_q <= pwr_good_d;
            ports_q    <= ports_d;
            valid_q    <= valid_d;
        end
    end

    // ------------------------------------------------------------------
    // Clock source and derived slow tick
    // ------------------------------------------------------------------
    logic       pll_sel_q, pll_sel_d;
    logic [1:0] div_q, div_d;
    logic       tick_q, tick_d;

    always_comb begin
        pll_sel_d = running & ~bypass;
        div_d     = div_q;
        tick_d    = 1'b0;
        if (running) begin
            if (div_q == hscd_pkg::SLOW_DIV_LAST) begin
                div_d  = 2'h0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 2'h1;
            end
        end else begin
            div_d = 2'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_sel_q <= 1'b0;
            div_q     <= 2'h0;
            tick_q    <= 1'b0;
        end else if (clk_en) begin
            pll_sel_q <= pll_sel_d;
            div_q     <= div_d;
            tick_q    <= tick_d;
        end
    end

    // ------------------------------------------------------------------
    // Port power and suspend outputs
    // ------------------------------------------------------------------
    logic [2:0] pwr_en_n_q, pwr_en_n_d;
    logic       susp_q, susp_d;
    logic [2:0] port_exists;

    assign port_exists = {three_ports, 2'b11};

    always_comb begin
        // Low level switches the external supply on
        pwr_en_n_d = ~(ctrl_q[2:0] & port_exists & {3{running}});
        susp_d     = running & ctrl_q[hscd_pkg::CTRL_SUSPEND_BIT];
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwr_en_n_q <= 3'h7;
            susp_q     <= 1'b0;
        end else if (clk_en) begin
            pwr_en_n_q <= pwr_en_n_d;
            susp_q     <= susp_d;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [hscd_pkg::DATA_W-1:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                hscd_pkg::REG_CTRL: begin
                    rdata_d[3:0] = ctrl_q;
                end
                hscd_pkg::REG_STRAPS: begin
                    rdata_d[hscd_pkg::STRAP_W-1:0]   = strap_q;
                    rdata_d[hscd_pkg::STRAP_VALID_BIT] = valid_q;
                end
                hscd_pkg::REG_HUB_CHAR: begin
                    rdata_d = hub_char_q;
                end
                hscd_pkg::REG_PWR_GOOD: begin
                    rdata_d[7:0] = pwr_good_q;
                end
                hscd_pkg::REG_PORT_COUNT: begin
                    rdata_d[1:0] = ports_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= '0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata           = rdata_q;
    assign port_power_enable_n = pwr_en_n_q;
    assign suspend_status_out  = susp_q;
    assign core_clock_pll      = pll_sel_q;
    assign slow_clock_tick     = tick_q;
    assign hub_characteristics = hub_char_q;
    assign power_on_to_good    = pwr_good_q;
    assign port_count          = ports_q;
    assign config_valid        = valid_q;

endmodule

// ### pkg/hscd_pkg.sv
package hscd_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_HZ          = 10_000_000;
    localparam int unsigned PLL_IN_MHZ        = 6;
    localparam int unsigned CORE_MHZ          = 48;
    localparam int unsigned SLOW_MHZ          = 12;
    localparam int unsigned PLL_MULT          = CORE_MHZ / PLL_IN_MHZ;
    localparam int unsigned SLOW_DIV          = CORE_MHZ / SLOW_MHZ;
    localparam logic [1:0]  SLOW_DIV_LAST     = 2'(SLOW_DIV - 1);
    localparam logic [2:0]  SETTLE_CYCLES     = 3'h4;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W            = 4;
    localparam int unsigned DATA_W            = 16;
    localparam logic [3:0]  REG_CTRL          = 4'h0;
    localparam logic [3:0]  REG_STRAPS        = 4'h1;
    localparam logic [3:0]  REG_HUB_CHAR      = 4'h2;
    localparam logic [3:0]  REG_PWR_GOOD      = 4'h3;
    localparam logic [3:0]  REG_PORT_COUNT    = 4'h4;

    // Control register fields
    localparam int unsigned CTRL_POWER_LSB    = 0;
    localparam int unsigned CTRL_SUSPEND_BIT  = 3;
    localparam logic [3:0]  CTRL_RESET        = 4'h0;

    // Strap vector layout
    localparam int unsigned STRAP_W           = 6;
    localparam int unsigned STRAP_BYPASS      = 0;
    localparam int unsigned STRAP_THREE_N     = 1;
    localparam int unsigned STRAP_BUS_PWR_N   = 2;
    localparam int unsigned STRAP_PROT_SW_N   = 3;
    localparam int unsigned STRAP_FIXED_LSB   = 4;
    localparam int unsigned STRAP_VALID_BIT   = 6;
    localparam logic [5:0]  STRAP_RESET       = 6'h00;

    // ------------------------------------------------------------------
    // Descriptor values
    // ------------------------------------------------------------------
    localparam int unsigned PORTS_MAX         = 3;
    localparam logic [1:0]  PORTS_THREE       = 2'h3;
    localparam logic [1:0]  PORTS_TWO         = 2'h2;
    localparam int unsigned HUB_CHAR_OC_BIT   = 4;
    localparam logic [1:0]  HUB_SW_PER_PORT   = 2'h1;
    localparam logic [1:0]  HUB_SW_NONE       = 2'h2;
    localparam int unsigned PWR_GOOD_MS       = 100;
    localparam int unsigned PWR_GOOD_MS_UNIT  = 2;
    localparam logic [7:0]  PWR_GOOD_SWITCHED = 8'(PWR_GOOD_MS / PWR_GOOD_MS_UNIT);
    localparam logic [7:0]  PWR_GOOD_NONE     = 8'h00;
    localparam logic [15:0] HUB_CHAR_RESET    = 16'h0000;

    typedef enum logic [0:0] {
        HSCD_SETTLE,
        HSCD_RUN
    } hscd_state_t;

endpackage

// ### verilog/hscd_strap_sync.sv
`timescale 1ns/1ns
module hscd_strap_sync (
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    input  wire logic                         clk_en,
    input  wire logic [hscd_pkg::STRAP_W-1:0] pins_in,
    output logic      [hscd_pkg::STRAP_W-1:0] level_out
);

    // ------------------------------------------------------------------
    // Three-stage filter per pin; level moves once stages two and three agree
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < hscd_pkg::STRAP_W; i = i + 1) begin : g_bit
            logic s1_q, s2_q, s3_q, lvl_q;
            logic s1_d, s2_d, s3_d, lvl_d;

            always_comb begin
                s1_d  = pins_in[i];
                s2_d  = s1_q;
                s3_d  = s2_q;
                lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    lvl_q <= 1'b0;
                end else if (clk_en) begin
                    s1_q  <= s1_d;
                    s2_q  <= s2_d;
                    s3_q  <= s3_d;
                    lvl_q <= lvl_d;
                end
            end

            assign level_out[i] = lvl_q;
        end
    endgenerate

endmodule

// ### verification/hscd_switch_model.sv
`timescale 1ns/1ns
module hscd_switch_model (
    input  wire logic [2:0] port_power_enable_n,
    output logic      [2:0] port_powered
);
    // External switch conducts while its enable is driven low
    assign port_powered = ~port_power_enable_n;
endmodule

// ### verification/hscd_checker.sv
`timescale 1ns/1ns
module hscd_checker (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic [hscd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [hscd_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [hscd_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [2:0]                  port_power_enable_n,
    input  wire logic                        suspend_status_out,
    input  wire logic                        core_clock_pll,
    input  wire logic                        slow_clock_tick,
    input  wire logic [15:0]                 hub_characteristics,
    input  wire logic [7:0]                  power_on_to_good,
    input  wire logic [1:0]                  port_count,
    input  wire logic                        config_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_EN_IDLE: assert property (!config_valid |-> port_power_enable_n == 3'h7)
        else $error("power enable active before config");
    AST_EN_FOLLOW: assert property (reg_wr && reg_addr == hscd_pkg::REG_CTRL && config_valid
        ##1 config_valid |=> port_power_enable_n[1:0] == ~$past(reg_wdata[1:0], 2))
        else $error("power enable does not follow control write");
    AST_SUSP: assert property (reg_wr && reg_addr == hscd_pkg::REG_CTRL && config_valid
        ##1 config_valid |=> suspend_status_out == $past(reg_wdata[3], 2))
        else $error("suspend output does not follow control write");
    AST_IDLE_OUT: assert property (!config_valid |-> !suspend_status_out && !core_clock_pll)
        else $error("suspend or pll select set before config");
    AST_PORT3: assert property (port_count == hscd_pkg::PORTS_TWO |-> port_power_enable_n[2])
        else $error("third port powered in two port mode");
    AST_COUNT: assert property (config_valid |-> port_count inside {2'h2, 2'h3})
        else $error("bad port count");
    AST_OC: assert property (hub_characteristics[4] |-> power_on_to_good ==
        hscd_pkg::PWR_GOOD_SWITCHED && hub_characteristics[1:0] == hscd_pkg::HUB_SW_PER_PORT)
        else $error("overcurrent bit outside bus powered mode");
    AST_NO_SW: assert property (config_valid && power_on_to_good == 8'h00
        |-> hub_characteristics == {14'h0000, hscd_pkg::HUB_SW_NONE})
        else $error("zero power good time with switching reported");
    AST_HOLD: assert property (config_valid && $past(config_valid) |->
        $stable(hub_characteristics) && $stable(port_count) && $stable(core_clock_pll))
        else $error("captured configuration changed");
    AST_TICK: assert property (slow_clock_tick |=> !slow_clock_tick [*3] ##1 slow_clock_tick)
        else $error("slow tick spacing wrong");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read slot");

    cover property (reg_wr && reg_addr == hscd_pkg::REG_CTRL);
    cover property ($rose(suspend_status_out));
    cover property (hub_characteristics[4]);
endmodule

bind hscd_top hscd_checker u_chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_power_enable_n, .suspend_status_out, .core_clock_pll, .slow_clock_tick,
    .hub_characteristics, .power_on_to_good, .port_count, .config_valid);

// ### verification/hscd_tb.sv
`timescale 1ns/1ns
module tb;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        core_clock_bypass_strap = 1'b0;
    logic        three_port_select_n = 1'b0;
    logic        bus_power_select_n = 1'b0;
    logic        overcurrent_protect_strap_n = 1'b0;
    logic [1:0]  fixed_port_count_sel = 2'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata, hub_characteristics;
    logic [7:0]  power_on_to_good;
    logic [2:0]  port_power_enable_n, port_powered;
    logic [1:0]  port_count;
    logic        suspend_status_out, core_clock_pll, slow_clock_tick, config_valid;
    int          mismatches = 0;
    int          cmp_count = 0;

    always #50 clock = ~clock;

    hscd_top uut (.clock, .rst_n, .clk_en, .core_clock_bypass_strap, .three_port_select_n,
        .bus_power_select_n, .overcurrent_protect_strap_n, .fixed_port_count_sel, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_power_enable_n, .suspend_status_out,
        .core_clock_pll, .slow_clock_tick, .hub_characteristics, .power_on_to_good,
        .port_count, .config_valid);
    hscd_switch_model sw (.port_power_enable_n, .port_powered);

    // ----------------
    // Shared tasks
    // ----------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input string what, input logic [15:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask

    // Straps are {fixed, shared, bus_n, three_n, bypass}, applied with reset
    task automatic start(input logic [5:0] s);
        @(posedge clock);
        rst_n <= 1'b0;
        {fixed_port_count_sel, overcurrent_protect_strap_n, bus_power_select_n,
            three_port_select_n, core_clock_bypass_strap} <= s;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 40 && config_valid !== 1'b1; i++) @(posedge clock);
        if (config_valid !== 1'b1) begin
            mismatches++;
            $display("Error config_valid expected 1 seen %b", config_valid);
            close_out();
        end else begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic expect_cfg(input logic [15:0] ch, input logic [7:0] pg,
                              input logic [1:0] pc, input logic pll);
        check("hub_char", hub_characteristics, ch);
        check("pwr_good", {8'h00, power_on_to_good}, {8'h00, pg});
        check("port_count", {14'h0000, port_count}, {14'h0000, pc});
        check("pll_sel", {15'h0000, core_clock_pll}, {15'h0000, pll});
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_config();
        logic [15:0] ch;
        logic [7:0]  pg;
        int          ticks;
        for (int s = 0; s < 16; s++) begin
            start({s[1:0], s[3:0]});
            ch = {11'h000, ~s[2] & s[3], 2'h0,
                  (s[2] & s[3]) ? hscd_pkg::HUB_SW_NONE : hscd_pkg::HUB_SW_PER_PORT};
            pg = (s[2] & s[3]) ? hscd_pkg::PWR_GOOD_NONE : hscd_pkg::PWR_GOOD_SWITCHED;
            expect_cfg(ch, pg, s[1] ? 2'h2 : 2'h3, ~s[0]);
            rd(hscd_pkg::REG_STRAPS, "straps", {9'h000, 1'b1, s[1:0], s[3:0]});
            rd(hscd_pkg::REG_HUB_CHAR, "hub_char_reg", ch);
            rd(hscd_pkg::REG_PWR_GOOD, "pwr_good_reg", {8'h00, pg});
            rd(hscd_pkg::REG_PORT_COUNT, "count_reg", s[1] ? 16'h0002 : 16'h0003);
            ticks = 0;
            repeat (40) begin
                @(posedge clock);
                #1;
                ticks += slow_clock_tick;
            end
            if (s[0] == 0) check("ticks", ticks[15:0], 16'h000A);
        end
        $display("test config finished");
    endtask

    task automatic t_ctrl();
        start(6'h00);
        wr(hscd_pkg::REG_CTRL, 16'h000F);
        rd(hscd_pkg::REG_CTRL, "ctrl", 16'h000F);
        check("enable_n", {13'h0000, port_power_enable_n}, 16'h0000);
        check("powered", {13'h0000, port_powered}, 16'h0007);
        check("suspend", {15'h0000, suspend_status_out}, 16'h0001);
        wr(hscd_pkg::REG_HUB_CHAR, 16'hFFFF);
        wr(4'h9, 16'hFFFF);
        rd(hscd_pkg::REG_HUB_CHAR, "ro_hub_char", 16'h0001);
        rd(4'h9, "unmapped", 16'h0000);
        wr(hscd_pkg::REG_CTRL, 16'h0000);
        rd(hscd_pkg::REG_CTRL, "ctrl_clr", 16'h0000);
        check("suspend_off", {15'h0000, suspend_status_out}, 16'h0000);
        check("enable_off", {13'h0000, port_power_enable_n}, 16'h0007);
        start(6'h02);
        wr(hscd_pkg::REG_CTRL, 16'h0007);
        rd(hscd_pkg::REG_CTRL, "ctrl_two", 16'h0007);
        check("enable_two", {13'h0000, port_power_enable_n}, 16'h0004);
        $display("test control finished");
    endtask

    task automatic t_static();
        start(6'h08);
        @(posedge clock);
        {fixed_port_count_sel, overcurrent_protect_strap_n, bus_power_select_n,
            three_port_select_n, core_clock_bypass_strap} <= 6'h37;
        repeat (20) @(posedge clock);
        #1;
        expect_cfg(16'h0011, hscd_pkg::PWR_GOOD_SWITCHED, 2'h3, 1'b1);
        start(6'h37);
        expect_cfg(16'h0001, hscd_pkg::PWR_GOOD_SWITCHED, 2'h2, 1'b0);
        $display("test static finished");
    endtask

    initial begin
        t_config();
        t_ctrl();
        t_static();
        close_out();
    end

    initial begin
        #2000000;
        mismatches++;
        $display("Error watchdog expected finish seen hang");
        close_out();
    end
endmodule
